// *** include/spc_pkg.sv ***
package spc_pkg;
	// ==========================================
	// register map, byte addresses
	localparam logic [7:0] SPC_P0_BASE = 8'h98;
	localparam logic [7:0] SPC_P1_BASE = 8'hb8;
	localparam logic [7:0] SPC_CTRL_OFS = 8'h00;
	localparam logic [7:0] SPC_DATA_OFS = 8'h04;
	localparam logic [7:0] SPC_CFG_OFS = 8'h08;
	localparam logic [7:0] SPC_ADDR_OFS = 8'h0c;
	localparam logic [7:0] SPC_PORT_SPAN = 8'h10;
	// ==========================================
	// control register fields
	localparam int SPC_MODE_HI_BIT = 7;
	localparam int SPC_MODE_LO_BIT = 6;
	localparam int SPC_MPF_BIT = 5;
	localparam int SPC_REN_BIT = 4;
	localparam int SPC_TB8_BIT = 3;
	localparam int SPC_RB8_BIT = 2;
	localparam int SPC_TI_BIT = 1;
	localparam int SPC_RI_BIT = 0;
	localparam logic [7:0] SPC_CTRL_RST = 8'h00;
	// ==========================================
	// configuration and address registers
	localparam int SPC_CFG_FES_BIT = 0;
	localparam int SPC_CFG_IRQEN_BIT = 1;
	localparam int SPC_CFG_SWAP_BIT = 2;
	localparam int SPC_CFG_DIV_LSB = 16;
	localparam logic [31:0] SPC_CFG_MASK = 32'hffff_0007;
	localparam logic [31:0] SPC_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] SPC_ADDR_MASK = 32'h0000_ffff;
	localparam logic [31:0] SPC_ADDR_RST = 32'h0000_0000;
	// ==========================================
	// timing
	localparam logic [3:0] SPC_M0_PER_SLOW = 4'hc;
	localparam logic [3:0] SPC_M0_PER_FAST = 4'h2;
	localparam logic [15:0] SPC_M2_TICK_DIV = 16'h0001;
	localparam logic [3:0] SPC_OVS_LAST = 4'hf;
	localparam logic [3:0] SPC_OVS_MID = 4'h7;
	localparam logic [3:0] SPC_RX_LAST8 = 4'h9;
	localparam logic [3:0] SPC_RX_LAST9 = 4'ha;
	localparam logic [3:0] SPC_TX_BITS8 = 4'ha;
	localparam logic [3:0] SPC_TX_BITS9 = 4'hb;
	localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		SPC_MODE_SHIFT,
		SPC_MODE_UART8,
		SPC_MODE_UART9_FIX,
		SPC_MODE_UART9_VAR
	} spc_mode_t;
	typedef struct packed {
		logic fes;
		logic irq_en;
		logic swap;
		logic [15:0] divisor;
		logic [7:0] given;
		logic [7:0] bcast;
	} spc_cfg_t;
endpackage : spc_pkg

// *** verif/spc_checker.sv ***
`timescale 1ns/1ns
module spc_checker
	import spc_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [7:0] s_axi_araddr, // ar addr
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [1:0] pin_b_out, // line drive
	input wire logic [1:0] serial_irq // irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========
	// register bus
	AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two edges after take");
	AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	AST_W_STALL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
	AST_AR_STALL: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read taken before answer");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
		|=> s_axi_rresp == SPC_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	// flags are only lowered by a register write
	AST_IRQ_STICKY: assert property (serial_irq[0] && !s_axi_bvalid |=> serial_irq[0])
		else $error("interrupt dropped without write");
	AST_RESET: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready &&
		!s_axi_bvalid && !s_axi_rvalid && serial_irq == 2'h0 && pin_b_out == 2'h3)
		else $error("reset state wrong");
	cover property (s_axi_bvalid && s_axi_bresp == SPC_RESP_SLVERR);
	cover property ($rose(serial_irq[0]));
	cover property ($fell(pin_b_out[0]));
endmodule : spc_checker

bind spc_top spc_checker spc_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .pin_b_out, .serial_irq);

// *** verif/spc_remote.sv ***
`timescale 1ns/1ns
module spc_remote
(
	input wire logic aclk, // clock
	input wire logic line_in, // from device
	output logic line_out // to device
);
	logic [8:0] got; // captured frame
	initial line_out = 1'b1;
	// ==========
	// frame out; line returns to idle high even after a bad stop
	task automatic send(input logic [7:0] d, input logic b9, u9, stp, input int bt);
		logic [10:0] f;
		f = u9 ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < (u9 ? 11 : 10); i++)
		begin
			@(posedge aclk);
			line_out <= f[i];
			repeat (bt - 1) @(posedge aclk);
		end
		@(posedge aclk);
		line_out <= 1'b1;
	endtask : send
	// ==========
	// frame in, sampled mid-bit
	task automatic take(input logic u9, input int bt);
		got = '0;
		@(posedge aclk iff !line_in);
		repeat (bt / 2) @(posedge aclk);
		for (int i = 0; i < (u9 ? 9 : 8); i++)
		begin
			repeat (bt) @(posedge aclk);
			got[i] = line_in;
		end
	endtask : take
endmodule : spc_remote

// *** verif/spc_top_test.sv ***
`timescale 1ns/1ns
module spc_top_test
	import spc_pkg::*;
;
	localparam logic [1:0] OK = SPC_RESP_OKAY;
	localparam logic [1:0] ER = SPC_RESP_SLVERR;
	logic aclk, aresetn, rem_tx;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, pin_a_in, pin_b_in, pin_a_out, pin_a_oe, pin_b_out;
	logic [1:0] pin_b_oe, serial_irq;
	int error_cnt, total_checks, n;
	// released b lines pulled high; released port 0 pin a carries the remote line
	assign pin_a_in = {1'b1, pin_a_oe[0] ? pin_a_out[0] : rem_tx};
	assign pin_b_in = pin_b_out | ~pin_b_oe;
	spc_top spc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_a_in, .pin_b_in, .pin_a_out,
		.pin_a_oe, .pin_b_out, .pin_b_oe, .serial_irq);
	spc_remote spc_remote_i (.aclk, .line_in(pin_b_in[0]), .line_out(rem_tx));
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ==========
	// checking and bus tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
	endtask : rd
	task automatic results();
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial
	begin
		#200000;
		error_cnt++;
		results();
	end
	// ==========
	// tests
	initial
	begin
		{aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h98, 32'h0, OK);
		rd(8'ha0, 32'h0, OK);
		chk("pins", 32'h0f, {26'h0, pin_a_oe, pin_b_oe, pin_b_out});
		wr(8'hc4, 32'h1234_5678, OK);
		rd(8'hc4, 32'h5678, OK);
		wr(8'h00, 32'h1, ER);
		rd(8'h00, 32'h0, ER);
		wr(8'ha0, 32'h2, OK);
		wr(8'h98, 32'h50, OK);
		fork
			wr(8'h9c, 32'ha5, OK);
			spc_remote_i.take(1'b0, 16);
			spc_remote_i.send(8'h3c, 1'b0, 1'b0, 1'b1, 16);
		join
		repeat (32) @(posedge aclk);
		chk("tx byte", 32'ha5, {24'h0, spc_remote_i.got[7:0]});
		rd(8'h98, 32'h57, OK);
		chk("irq", 32'h1, {30'h0, serial_irq});
		rd(8'h9c, 32'h3c, OK);
		// old byte must survive while the next one shifts in
		wr(8'h98, 32'h50, OK);
		fork
			spc_remote_i.send(8'h11, 1'b0, 1'b0, 1'b1, 16);
			begin
				repeat (80) @(posedge aclk);
				rd(8'h9c, 32'h3c, OK);
			end
		join
		rd(8'h9c, 32'h11, OK);
		spc_remote_i.send(8'h22, 1'b0, 1'b0, 1'b1, 16);
		rd(8'h9c, 32'h11, OK);
		wr(8'ha0, 32'h3, OK);
		wr(8'h98, 32'h50, OK);
		spc_remote_i.send(8'h33, 1'b0, 1'b0, 1'b0, 16);
		rd(8'h98, 32'hd1, OK);
		wr(8'h98, 32'h50, OK);
		rd(8'h98, 32'h50, OK);
		wr(8'ha0, 32'h2, OK);
		wr(8'ha4, 32'hff42, OK);
		wr(8'h98, 32'hb8, OK);
		spc_remote_i.send(8'h55, 1'b1, 1'b1, 1'b1, 32);
		rd(8'h98, 32'hb8, OK);
		fork
			wr(8'h9c, 32'h81, OK);
			spc_remote_i.take(1'b1, 32);
			spc_remote_i.send(8'h42, 1'b1, 1'b1, 1'b1, 32);
		join
		repeat (64) @(posedge aclk);
		chk("frame9", 32'h181, {23'h0, spc_remote_i.got});
		rd(8'h98, 32'hbf, OK);
		rd(8'h9c, 32'h42, OK);
		wr(8'h98, 32'hc0, OK);
		fork
			wr(8'h9c, 32'h5a, OK);
			spc_remote_i.take(1'b1, 16);
		join
		chk("frame9", 32'h05a, {23'h0, spc_remote_i.got});
		// shift clock low half is half the period
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h98, k ? 32'h20 : 32'h0, OK);
			wr(8'h9c, 32'h96, OK);
			@(posedge aclk iff pin_b_out[0]);
			@(posedge aclk iff !pin_b_out[0]);
			n = 0;
			do
			begin
				@(posedge aclk);
				n++;
			end while (!pin_b_out[0] && n < 50);
			chk("half period", k ? 32'd1 : 32'd6, n);
			// let the byte finish before the next mode change
			repeat (100) @(posedge aclk);
			rd(8'h98, k ? 32'h22 : 32'h02, OK);
		end
		// shift receive of an idle high line
		wr(8'h98, 32'h30, OK);
		repeat (20) @(posedge aclk);
		rd(8'h98, 32'h31, OK);
		rd(8'h9c, 32'hff, OK);
		results();
	end
endmodule : spc_top_test

// *** verilog/spc_top.sv ***
`timescale 1ns/1ns
module spc_port
	import spc_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, low
	input wire spc_cfg_t cfg, // configuration
	input wire logic ctrl_wr, // control write strobe
	input wire logic data_wr, // data write strobe
	input wire logic [7:0] wbyte, // write byte
	input wire logic pin_a_in, // pin a level
	input wire logic pin_b_in, // pin b level
	output logic pin_a_out, // pin a drive
	output logic pin_a_oe, // pin a enable
	output logic pin_b_out, // pin b drive
	output logic pin_b_oe, // pin b enable
	output logic [7:0] ctrl_rd, // control readback
	output logic [7:0] rx_hold, // receive holding
	output logic irq // interrupt request
);
	typedef enum {TX_IDLE, TX_SEND} spc_tx_t;
	typedef enum {RX_IDLE, RX_BUSY} spc_rx_t;
	typedef enum {M0_IDLE, M0_TX, M0_RX} spc_m0_t;
	logic sm0_reg, fe_reg, sm1_reg, mpf_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg;
	spc_mode_t mode;
	logic [15:0] div_cnt_reg;
	logic [15:0] div;
	logic tick, rx_in, rx_prev_reg;
	spc_tx_t tx_state_reg;
	logic [10:0] tx_sh_reg;
	logic [3:0] tx_left_reg, tx_tcnt_reg;
	spc_rx_t rx_state_reg;
	logic [8:0] rx_sh_reg;
	logic [3:0] rx_idx_reg, rx_tcnt_reg;
	spc_m0_t m0_state_reg;
	logic [7:0] m0_sh_reg;
	logic [3:0] m0_ph_reg, m0_per;
	logic [2:0] m0_bit_reg;
	logic m0_clk_reg;
	logic tx_ti_set, m0_ti_set, rx_ri_set, m0_ri_set, rx_fe_set;
	logic rx_last, rx_sample, rx_stop, rx_ninth, rx_valid;
	logic [7:0] rx_data;
	logic txd_val, rxd_val, rxd_en;

	// ==========================================
	// control register and flags
	assign mode = spc_mode_t'({sm0_reg, sm1_reg});
	assign ctrl_rd = {cfg.fes ? fe_reg : sm0_reg, sm1_reg, mpf_reg, ren_reg,
		tb8_reg, rb8_reg, ti_reg, ri_reg};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{sm0_reg, sm1_reg, mpf_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg} <= SPC_CTRL_RST;
			fe_reg <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
			begin
				if (cfg.fes)
					fe_reg <= wbyte[SPC_MODE_HI_BIT];
				else
					sm0_reg <= wbyte[SPC_MODE_HI_BIT];
				sm1_reg <= wbyte[SPC_MODE_LO_BIT];
				mpf_reg <= wbyte[SPC_MPF_BIT];
				ren_reg <= wbyte[SPC_REN_BIT];
				tb8_reg <= wbyte[SPC_TB8_BIT];
				rb8_reg <= wbyte[SPC_RB8_BIT];
				ti_reg <= wbyte[SPC_TI_BIT];
				ri_reg <= wbyte[SPC_RI_BIT];
			end
			// hardware sets win over a same-cycle software clear
			if (rx_fe_set)
				fe_reg <= 1'b1;
			if (tx_ti_set || m0_ti_set)
				ti_reg <= 1'b1;
			if (rx_ri_set || m0_ri_set)
				ri_reg <= 1'b1;
			if (rx_ri_set)
				rb8_reg <= rx_ninth;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= cfg.irq_en && (ti_reg || ri_reg);
	end

	// ==========================================
	// oversampling tick, sixteen per bit
	assign div = (mode == SPC_MODE_UART9_FIX) ? SPC_M2_TICK_DIV : cfg.divisor;
	assign tick = (div_cnt_reg >= div);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tick)
			div_cnt_reg <= 16'h0000;
		else
			div_cnt_reg <= div_cnt_reg + 16'h0001;
	end

	// ==========================================
	// asynchronous transmitter
	// a write while a frame is still going out is dropped
	assign tx_ti_set = (tx_state_reg == TX_SEND) && tick && (tx_tcnt_reg == SPC_OVS_LAST)
		&& (tx_left_reg == 4'h2);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state_reg <= TX_IDLE;
			tx_sh_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			tx_tcnt_reg <= 4'h0;
		end
		else
		begin
			case (tx_state_reg)
				TX_IDLE:
				begin
					if (data_wr && mode != SPC_MODE_SHIFT)
					begin
						tx_state_reg <= TX_SEND;
						tx_tcnt_reg <= 4'h0;
						if (mode == SPC_MODE_UART8)
						begin
							tx_sh_reg <= {2'h3, wbyte, 1'b0};
							tx_left_reg <= SPC_TX_BITS8;
						end
						else
						begin
							tx_sh_reg <= {1'b1, tb8_reg, wbyte, 1'b0};
							tx_left_reg <= SPC_TX_BITS9;
						end
					end
				end
				TX_SEND:
				begin
					if (tick)
					begin
						tx_tcnt_reg <= tx_tcnt_reg + 4'h1;
						if (tx_tcnt_reg == SPC_OVS_LAST)
						begin
							tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
							tx_left_reg <= tx_left_reg - 4'h1;
							if (tx_left_reg == 4'h1)
								tx_state_reg <= TX_IDLE;
						end
					end
				end
				default:
					tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// ==========================================
	// asynchronous receiver, runs beside the transmitter
	assign rx_in = cfg.swap ? pin_b_in : pin_a_in;
	assign rx_sample = (rx_state_reg == RX_BUSY) && tick && (rx_tcnt_reg == SPC_OVS_MID);
	assign rx_last = (rx_idx_reg == ((mode == SPC_MODE_UART8) ? SPC_RX_LAST8 : SPC_RX_LAST9));
	assign rx_stop = rx_in;
	assign rx_data = (mode == SPC_MODE_UART8) ? rx_sh_reg[8:1] : rx_sh_reg[7:0];
	assign rx_ninth = (mode == SPC_MODE_UART8) ? rx_in : rx_sh_reg[8];
	// filter bit: stop level in mode one, ninth bit otherwise
	assign rx_valid = !mpf_reg || (rx_ninth
		&& (rx_data == cfg.given || rx_data == cfg.bcast));
	// an unread byte is kept; a new frame is dropped while the done flag is set
	assign rx_ri_set = rx_sample && rx_last && rx_valid && !ri_reg;
	assign rx_fe_set = rx_sample && rx_last && !rx_stop;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_prev_reg <= 1'b1;
		else
			rx_prev_reg <= rx_in;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_state_reg <= RX_IDLE;
			rx_sh_reg <= 9'h000;
			rx_idx_reg <= 4'h0;
			rx_tcnt_reg <= 4'h0;
		end
		else
		begin
			case (rx_state_reg)
				RX_IDLE:
				begin
					if (ren_reg && mode != SPC_MODE_SHIFT && rx_prev_reg && !rx_in)
					begin
						rx_state_reg <= RX_BUSY;
						rx_idx_reg <= 4'h0;
						rx_tcnt_reg <= 4'h0;
					end
				end
				RX_BUSY:
				begin
					if (tick)
						rx_tcnt_reg <= rx_tcnt_reg + 4'h1;
					if (rx_sample)
					begin
						rx_idx_reg <= rx_idx_reg + 4'h1;
						if (rx_idx_reg == 4'h0 && rx_in)
							rx_state_reg <= RX_IDLE; // glitch, not a start bit
						else if (rx_last)
							rx_state_reg <= RX_IDLE;
						else if (rx_idx_reg != 4'h0)
							rx_sh_reg <= {rx_in, rx_sh_reg[8:1]};
					end
				end
				default:
					rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ==========================================
	// receive holding register, shared by both engines
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_hold <= 8'h00;
		else if (rx_ri_set)
			rx_hold <= rx_data;
		else if (m0_ri_set)
			rx_hold <= m0_sh_reg;
	end

	// ==========================================
	// synchronous shift engine, half-duplex by nature
	assign m0_per = mpf_reg ? SPC_M0_PER_FAST : SPC_M0_PER_SLOW;
	assign m0_ti_set = (m0_state_reg == M0_TX) && (m0_ph_reg == m0_per - 4'h1)
		&& (m0_bit_reg == 3'h7);
	assign m0_ri_set = (m0_state_reg == M0_RX) && (m0_ph_reg == m0_per - 4'h1)
		&& (m0_bit_reg == 3'h7);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			m0_state_reg <= M0_IDLE;
			m0_sh_reg <= 8'h00;
			m0_ph_reg <= 4'h0;
			m0_bit_reg <= 3'h0;
			m0_clk_reg <= 1'b1;
		end
		else
		begin
			case (m0_state_reg)
				M0_IDLE:
				begin
					m0_ph_reg <= 4'h0;
					m0_bit_reg <= 3'h0;
					m0_clk_reg <= 1'b1;
					if (mode == SPC_MODE_SHIFT && data_wr)
					begin
						m0_state_reg <= M0_TX;
						m0_sh_reg <= wbyte;
						m0_clk_reg <= 1'b0;
					end
					else if (mode == SPC_MODE_SHIFT && ren_reg && !ri_reg)
					begin
						m0_state_reg <= M0_RX;
						m0_clk_reg <= 1'b0;
					end
				end
				M0_TX, M0_RX:
				begin
					m0_ph_reg <= m0_ph_reg + 4'h1;
					if (m0_ph_reg == (m0_per >> 1) - 4'h1)
					begin
						m0_clk_reg <= 1'b1;
						if (m0_state_reg == M0_RX)
							m0_sh_reg <= {rx_in, m0_sh_reg[7:1]};
					end
					if (m0_ph_reg == m0_per - 4'h1)
					begin
						m0_ph_reg <= 4'h0;
						m0_bit_reg <= m0_bit_reg + 3'h1;
						if (m0_state_reg == M0_TX)
							m0_sh_reg <= {1'b1, m0_sh_reg[7:1]};
						if (m0_bit_reg == 3'h7)
						begin
							m0_state_reg <= M0_IDLE;
							m0_clk_reg <= 1'b1;
						end
						else
							m0_clk_reg <= 1'b0;
					end
				end
				default:
					m0_state_reg <= M0_IDLE;
			endcase
		end
	end

	// ==========================================
	// pin roles: a is receive or shift data, b is transmit or shift clock, unless swapped
	always_comb
	begin
		txd_val = tx_sh_reg[0];
		rxd_val = 1'b1;
		rxd_en = 1'b0;
		if (mode == SPC_MODE_SHIFT)
		begin
			txd_val = m0_clk_reg;
			rxd_val = m0_sh_reg[0];
			rxd_en = (m0_state_reg == M0_TX);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_a_out <= 1'b1;
			pin_a_oe <= 1'b0;
			pin_b_out <= 1'b1;
			pin_b_oe <= 1'b1;
		end
		else
		begin
			pin_a_out <= cfg.swap ? txd_val : rxd_val;
			pin_a_oe <= cfg.swap ? 1'b1 : rxd_en;
			pin_b_out <= cfg.swap ? rxd_val : txd_val;
			pin_b_oe <= cfg.swap ? rxd_en : 1'b1;
		end
	end
endmodule : spc_port

module spc_top
	import spc_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // response valid
	input wire logic s_axi_bready, // response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [1:0] pin_a_in, // pin a level per port
	input wire logic [1:0] pin_b_in, // pin b level per port
	output logic [1:0] pin_a_out, // pin a drive
	output logic [1:0] pin_a_oe, // pin a enable
	output logic [1:0] pin_b_out, // pin b drive
	output logic [1:0] pin_b_oe, // pin b enable
	output logic [1:0] serial_irq // interrupt per port
);
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_held_reg, w_held_reg, do_wr;
	logic [31:0] cfg_word_reg [2];
	logic [31:0] addr_word_reg [2];
	logic [7:0] ctrl_rd [2];
	logic [7:0] rx_hold [2];
	logic [3:0] wdec, rdec;
	logic [31:0] strb_mask;

	// {hit, port, register index}
	function automatic logic [3:0] spc_decode(input logic [7:0] a);
		logic [7:0] o0;
		logic [7:0] o1;
		o0 = a - SPC_P0_BASE;
		o1 = a - SPC_P1_BASE;
		if (o0 < SPC_PORT_SPAN && o0[1:0] == 2'h0)
			spc_decode = {2'h2, o0[3:2]};
		else if (o1 < SPC_PORT_SPAN && o1[1:0] == 2'h0)
			spc_decode = {2'h3, o1[3:2]};
		else
			spc_decode = 4'h0;
	endfunction : spc_decode

	assign wdec = spc_decode(awaddr_reg);
	assign rdec = spc_decode(s_axi_araddr);
	assign do_wr = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
		{8{wstrb_reg[0]}}};

	// ==========================================
	// axi write channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SPC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_held_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wdec[3] ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================
	// axi read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SPC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= rdec[3] ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
			case ({rdec[3], rdec[1:0]})
				{1'b1, SPC_CTRL_OFS[3:2]}: s_axi_rdata <= {24'h000000, ctrl_rd[rdec[2]]};
				{1'b1, SPC_DATA_OFS[3:2]}: s_axi_rdata <= {24'h000000, rx_hold[rdec[2]]};
				{1'b1, SPC_CFG_OFS[3:2]}: s_axi_rdata <= cfg_word_reg[rdec[2]];
				{1'b1, SPC_ADDR_OFS[3:2]}: s_axi_rdata <= addr_word_reg[rdec[2]];
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// per-port configuration and port instances
	for (genvar i = 0; i < 2; i++)
	begin : g_port
		logic hit;
		spc_cfg_t cfg;
		assign hit = do_wr && wdec[3] && (wdec[2] == 1'(i));
		assign cfg.fes = cfg_word_reg[i][SPC_CFG_FES_BIT];
		assign cfg.irq_en = cfg_word_reg[i][SPC_CFG_IRQEN_BIT];
		// only the first port can swap its pins
		assign cfg.swap = (i == 0) && cfg_word_reg[i][SPC_CFG_SWAP_BIT];
		assign cfg.divisor = cfg_word_reg[i][SPC_CFG_DIV_LSB +: 16];
		assign cfg.given = addr_word_reg[i][7:0];
		assign cfg.bcast = addr_word_reg[i][15:8];

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				cfg_word_reg[i] <= SPC_CFG_RST;
				addr_word_reg[i] <= SPC_ADDR_RST;
			end
			else if (hit && wdec[1:0] == SPC_CFG_OFS[3:2])
				cfg_word_reg[i] <= ((cfg_word_reg[i] & ~strb_mask)
					| (wdata_reg & strb_mask)) & SPC_CFG_MASK;
			else if (hit && wdec[1:0] == SPC_ADDR_OFS[3:2])
				addr_word_reg[i] <= ((addr_word_reg[i] & ~strb_mask)
					| (wdata_reg & strb_mask)) & SPC_ADDR_MASK;
		end

		spc_port u_port (
			.aclk(aclk),
			.aresetn(aresetn),
			.cfg(cfg),
			.ctrl_wr(hit && wdec[1:0] == SPC_CTRL_OFS[3:2] && wstrb_reg[0]),
			.data_wr(hit && wdec[1:0] == SPC_DATA_OFS[3:2] && wstrb_reg[0]),
			.wbyte(wdata_reg[7:0]),
			.pin_a_in(pin_a_in[i]),
			.pin_b_in(pin_b_in[i]),
			.pin_a_out(pin_a_out[i]),
			.pin_a_oe(pin_a_oe[i]),
			.pin_b_out(pin_b_out[i]),
			.pin_b_oe(pin_b_oe[i]),
			.ctrl_rd(ctrl_rd[i]),
			.rx_hold(rx_hold[i]),
			.irq(serial_irq[i])
		);
	end
endmodule : spc_top
